/* aig_pkg.sv */
`default_nettype none
package aig_pkg;
	localparam int NCONV   = 2;
	localparam int NGRP    = 9;
	localparam int NGRP_LO = 5;
	localparam int NCMP    = 4;
	localparam int NTAB    = 9;
	localparam int NCCMP   = 2;
	localparam int CNT_W   = 4;
	localparam int AW      = 8;
	localparam int DW      = 32;

	// register byte offsets
	localparam logic [AW-1:0] OFS_CONV_EN   = 8'h00;
	localparam logic [AW-1:0] OFS_CONV_STAT = 8'h04;
	localparam logic [AW-1:0] OFS_SCAN_EN   = 8'h08;
	localparam logic [AW-1:0] OFS_SCAN_STAT = 8'h0C;
	localparam logic [AW-1:0] OFS_LIM_EN    = 8'h10;
	localparam logic [AW-1:0] OFS_LIM_STAT  = 8'h14;
	localparam logic [AW-1:0] OFS_CMP_EN    = 8'h18;
	localparam logic [AW-1:0] OFS_CMP_STAT  = 8'h1C;
	localparam logic [AW-1:0] OFS_CCMP_CFG  = 8'h20;
	localparam logic [AW-1:0] OFS_FIFO_EN   = 8'h24;
	localparam logic [AW-1:0] OFS_FIFO_OVF  = 8'h28;
	localparam logic [AW-1:0] OFS_FIFO_THR0 = 8'h2C;
	localparam logic [AW-1:0] OFS_FIFO_THR1 = 8'h30;
	localparam logic [AW-1:0] OFS_IRQ_STAT  = 8'h34;

	// field positions in the converter enable / status words
	localparam int ERR_LSB = 0;
	localparam int CAL_LSB = 2;
	localparam int OVF_LSB = 4;
	localparam int CONV_W  = 6;
	// composite config: one half-word per composite request
	localparam int CCMP_STRIDE  = 16;
	localparam int CCMP_AND_OFS = 9;
	localparam int CCMP_EN_OFS  = 10;
	// groups whose thresholds sit in the first threshold word
	localparam int THR0_GRPS = 8;

	localparam logic [DW-1:0]     RST_WORD = 32'h0000_0000;
	localparam logic [CNT_W-1:0]  RST_THR  = 4'h0;

	typedef struct packed {
		logic [NCONV-1:0] conv_err;
		logic [NCONV-1:0] cal_done;
		logic [NCONV-1:0] res_ovf;
		logic [NGRP-1:0]  scan_end;
		logic [NGRP-1:0]  scan_forced;
		logic [NGRP-1:0]  lim_clip;
		logic [NTAB-1:0]  cmp_match;
		logic [NGRP-1:0]  fifo_ovf;
	} aig_evt_s;

	typedef struct packed {
		logic [NGRP-1:0][CNT_W-1:0] vacant;
		logic [NGRP-1:0]            flush;
	} aig_fifo_s;

	typedef struct packed {
		logic [NCONV-1:0]   conv_error_irq;
		logic [NCONV-1:0]   cal_done_irq;
		logic [NGRP_LO-1:0] scan_done_irq;
		logic               scan_done_hi_irq;
		logic               limiter_clip_irq;
		logic [NCONV-1:0]   result_overflow_irq;
		logic [NCMP-1:0]    cmp_match_irq;
		logic [NCCMP-1:0]   composite_match_irq;
		logic [NGRP_LO-1:0] fifo_read_req_irq;
		logic               fifo_read_req_hi_irq;
		logic               fifo_overflow_irq;
	} aig_irq_s;
endpackage : aig_pkg
`default_nettype wire

/* aig_irq_gate.sv */
// How it works
// - error request per converter while its enable and error flag are set.
// - calibration-done request per converter while enable and done flag are set.
// - groups zero to four each drive their own scan-done request.
// - groups five to eight share one scan-done request.
// - a scan ended by forced stop sets no scan-done flag.
// - one limiter-clip request from any enabled group clip flag.
// - result-overflow request per converter while enable and flag are set.
// - compare tables zero to three each drive a match request.
// - two composite requests combine flags of several compare tables.
// - groups zero to four request FIFO read when vacant count at or below threshold.
// - groups five to eight share the same FIFO read-request test.
// - FIFO read request held off while the group's flush flag is set.
// - one FIFO-overflow request from any enabled group overflow flag.
`timescale 1ns/1ps
`default_nettype none
module aig_irq_gate (
	input  wire logic                   core_clk,
	input  wire logic                   arst_n,
	input  wire logic [aig_pkg::AW-1:0] reg_addr,
	input  wire logic [aig_pkg::DW-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [aig_pkg::DW-1:0] reg_rdata,
	input  wire aig_pkg::aig_evt_s      evt,
	input  wire aig_pkg::aig_fifo_s     fifo_st,
	output aig_pkg::aig_irq_s           irq
);
	logic [aig_pkg::CONV_W-1:0]                  conv_en_r;
	logic [aig_pkg::CONV_W-1:0]                  conv_flag_r;
	logic [aig_pkg::NGRP-1:0]                    scan_en_r;
	logic [aig_pkg::NGRP-1:0]                    scan_flag_r;
	logic [aig_pkg::NGRP-1:0]                    lim_en_r;
	logic [aig_pkg::NGRP-1:0]                    lim_flag_r;
	logic [aig_pkg::NCMP-1:0]                    cmp_en_r;
	logic [aig_pkg::NTAB-1:0]                    cmp_flag_r;
	logic [aig_pkg::NCCMP-1:0][aig_pkg::NTAB-1:0] ccmp_mask_r;
	logic [aig_pkg::NCCMP-1:0]                   ccmp_and_r;
	logic [aig_pkg::NCCMP-1:0]                   ccmp_en_r;
	logic [aig_pkg::NGRP-1:0]                    fifo_en_r;
	logic [aig_pkg::NGRP-1:0]                    fifo_ovf_r;
	logic [aig_pkg::NGRP-1:0][aig_pkg::CNT_W-1:0] fifo_thr_r;
	logic [aig_pkg::DW-1:0]                      rdata_nxt;
	logic [aig_pkg::NGRP-1:0]                    fifo_req;
	logic [aig_pkg::NCCMP-1:0]                   ccmp_hit;
	aig_pkg::aig_irq_s                           irq_nxt;
	logic [aig_pkg::DW-1:0]                      irq_word;

	function automatic logic wr_at(input logic [aig_pkg::AW-1:0] ofs);
		wr_at = reg_wr && (reg_addr == ofs);
	endfunction : wr_at

	// enables and configuration, plain read/write
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_en_r   <= '0;
			scan_en_r   <= '0;
			lim_en_r    <= '0;
			cmp_en_r    <= '0;
			ccmp_mask_r <= '0;
			ccmp_and_r  <= '0;
			ccmp_en_r   <= '0;
			fifo_en_r   <= '0;
		end else begin
			if (wr_at(aig_pkg::OFS_CONV_EN))
				conv_en_r <= reg_wdata[aig_pkg::CONV_W-1:0];
			if (wr_at(aig_pkg::OFS_SCAN_EN))
				scan_en_r <= reg_wdata[aig_pkg::NGRP-1:0];
			if (wr_at(aig_pkg::OFS_LIM_EN))
				lim_en_r <= reg_wdata[aig_pkg::NGRP-1:0];
			if (wr_at(aig_pkg::OFS_CMP_EN))
				cmp_en_r <= reg_wdata[aig_pkg::NCMP-1:0];
			if (wr_at(aig_pkg::OFS_FIFO_EN))
				fifo_en_r <= reg_wdata[aig_pkg::NGRP-1:0];
			if (wr_at(aig_pkg::OFS_CCMP_CFG)) begin
				for (int k = 0; k < aig_pkg::NCCMP; k++) begin
					ccmp_mask_r[k] <= reg_wdata[k*aig_pkg::CCMP_STRIDE +: aig_pkg::NTAB];
					ccmp_and_r[k]  <= reg_wdata[k*aig_pkg::CCMP_STRIDE + aig_pkg::CCMP_AND_OFS];
					ccmp_en_r[k]   <= reg_wdata[k*aig_pkg::CCMP_STRIDE + aig_pkg::CCMP_EN_OFS];
				end
			end
		end
	end

	// thresholds, two words
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_thr_r <= {aig_pkg::NGRP{aig_pkg::RST_THR}};
		end else begin
			if (wr_at(aig_pkg::OFS_FIFO_THR0))
				fifo_thr_r[aig_pkg::THR0_GRPS-1:0] <= reg_wdata;
			if (wr_at(aig_pkg::OFS_FIFO_THR1))
				fifo_thr_r[aig_pkg::NGRP-1] <= reg_wdata[aig_pkg::CNT_W-1:0];
		end
	end

	// sticky flags
	// write one to clear; a same-cycle event wins so none is lost
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_flag_r <= '0;
			scan_flag_r <= '0;
			lim_flag_r  <= '0;
			cmp_flag_r  <= '0;
			fifo_ovf_r  <= '0;
		end else begin
			conv_flag_r <= (conv_flag_r & ~({aig_pkg::CONV_W{wr_at(aig_pkg::OFS_CONV_STAT)}}
				& reg_wdata[aig_pkg::CONV_W-1:0])) | {evt.res_ovf, evt.cal_done, evt.conv_err};
			scan_flag_r <= (scan_flag_r & ~({aig_pkg::NGRP{wr_at(aig_pkg::OFS_SCAN_STAT)}}
				& reg_wdata[aig_pkg::NGRP-1:0])) | (evt.scan_end & ~evt.scan_forced);
			lim_flag_r  <= (lim_flag_r & ~({aig_pkg::NGRP{wr_at(aig_pkg::OFS_LIM_STAT)}}
				& reg_wdata[aig_pkg::NGRP-1:0])) | evt.lim_clip;
			cmp_flag_r  <= (cmp_flag_r & ~({aig_pkg::NTAB{wr_at(aig_pkg::OFS_CMP_STAT)}}
				& reg_wdata[aig_pkg::NTAB-1:0])) | evt.cmp_match;
			fifo_ovf_r  <= (fifo_ovf_r & ~({aig_pkg::NGRP{wr_at(aig_pkg::OFS_FIFO_OVF)}}
				& reg_wdata[aig_pkg::NGRP-1:0])) | evt.fifo_ovf;
		end
	end

	generate
		for (genvar g = 0; g < aig_pkg::NGRP; g++) begin : g_fifo
			assign fifo_req[g] = fifo_en_r[g] && !fifo_st.flush[g]
				&& (fifo_st.vacant[g] <= fifo_thr_r[g]);
		end
		for (genvar k = 0; k < aig_pkg::NCCMP; k++) begin : g_ccmp
			assign ccmp_hit[k] = ccmp_en_r[k] && (|ccmp_mask_r[k]) && (ccmp_and_r[k]
				? ((cmp_flag_r & ccmp_mask_r[k]) == ccmp_mask_r[k])
				: (|(cmp_flag_r & ccmp_mask_r[k])));
		end
	endgenerate

	always_comb begin
		irq_nxt.conv_error_irq      = conv_en_r[aig_pkg::ERR_LSB +: aig_pkg::NCONV]
			& conv_flag_r[aig_pkg::ERR_LSB +: aig_pkg::NCONV];
		irq_nxt.cal_done_irq        = conv_en_r[aig_pkg::CAL_LSB +: aig_pkg::NCONV]
			& conv_flag_r[aig_pkg::CAL_LSB +: aig_pkg::NCONV];
		irq_nxt.scan_done_irq       = scan_en_r[aig_pkg::NGRP_LO-1:0] & scan_flag_r[aig_pkg::NGRP_LO-1:0];
		irq_nxt.scan_done_hi_irq    = |(scan_en_r[aig_pkg::NGRP-1:aig_pkg::NGRP_LO]
			& scan_flag_r[aig_pkg::NGRP-1:aig_pkg::NGRP_LO]);
		irq_nxt.limiter_clip_irq    = |(lim_en_r & lim_flag_r);
		irq_nxt.result_overflow_irq = conv_en_r[aig_pkg::OVF_LSB +: aig_pkg::NCONV]
			& conv_flag_r[aig_pkg::OVF_LSB +: aig_pkg::NCONV];
		irq_nxt.cmp_match_irq       = cmp_en_r & cmp_flag_r[aig_pkg::NCMP-1:0];
		irq_nxt.composite_match_irq = ccmp_hit;
		irq_nxt.fifo_read_req_irq   = fifo_req[aig_pkg::NGRP_LO-1:0];
		irq_nxt.fifo_read_req_hi_irq = |fifo_req[aig_pkg::NGRP-1:aig_pkg::NGRP_LO];
		irq_nxt.fifo_overflow_irq   = |(fifo_en_r & fifo_ovf_r);
	end

	// registered so the interrupt controller sees glitch-free levels
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			irq <= '0;
		else
			irq <= irq_nxt;
	end

	assign irq_word = aig_pkg::DW'(irq);

	always_comb begin
		rdata_nxt = aig_pkg::RST_WORD;
		case (reg_addr)
			aig_pkg::OFS_CONV_EN:   rdata_nxt = aig_pkg::DW'(conv_en_r);
			aig_pkg::OFS_CONV_STAT: rdata_nxt = aig_pkg::DW'(conv_flag_r);
			aig_pkg::OFS_SCAN_EN:   rdata_nxt = aig_pkg::DW'(scan_en_r);
			aig_pkg::OFS_SCAN_STAT: rdata_nxt = aig_pkg::DW'(scan_flag_r);
			aig_pkg::OFS_LIM_EN:    rdata_nxt = aig_pkg::DW'(lim_en_r);
			aig_pkg::OFS_LIM_STAT:  rdata_nxt = aig_pkg::DW'(lim_flag_r);
			aig_pkg::OFS_CMP_EN:    rdata_nxt = aig_pkg::DW'(cmp_en_r);
			aig_pkg::OFS_CMP_STAT:  rdata_nxt = aig_pkg::DW'(cmp_flag_r);
			aig_pkg::OFS_CCMP_CFG: begin
				for (int k = 0; k < aig_pkg::NCCMP; k++) begin
					rdata_nxt[k*aig_pkg::CCMP_STRIDE +: aig_pkg::NTAB] = ccmp_mask_r[k];
					rdata_nxt[k*aig_pkg::CCMP_STRIDE + aig_pkg::CCMP_AND_OFS] = ccmp_and_r[k];
					rdata_nxt[k*aig_pkg::CCMP_STRIDE + aig_pkg::CCMP_EN_OFS] = ccmp_en_r[k];
				end
			end
			aig_pkg::OFS_FIFO_EN:   rdata_nxt = aig_pkg::DW'(fifo_en_r);
			aig_pkg::OFS_FIFO_OVF:  rdata_nxt = aig_pkg::DW'(fifo_ovf_r);
			aig_pkg::OFS_FIFO_THR0: rdata_nxt = fifo_thr_r[aig_pkg::THR0_GRPS-1:0];
			aig_pkg::OFS_FIFO_THR1: rdata_nxt = aig_pkg::DW'(fifo_thr_r[aig_pkg::NGRP-1]);
			aig_pkg::OFS_IRQ_STAT:  rdata_nxt = irq_word;
			default:                rdata_nxt = aig_pkg::RST_WORD;
		endcase
	end

	// data valid only the cycle after the read strobe
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= aig_pkg::RST_WORD;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
		else
			reg_rdata <= aig_pkg::RST_WORD;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_err_seen;
		evt.conv_err[0] && conv_en_r[aig_pkg::ERR_LSB];
	endsequence
	sequence s_err_flagged;
		conv_flag_r[aig_pkg::ERR_LSB] ##1 (irq.conv_error_irq[0] || $past(reg_wr));
	endsequence

	a_err_irq_raise: assert property (s_err_seen |=> s_err_flagged)
		else $error("error event did not raise error request");
	a_cal_irq_cause: assert property (irq.cal_done_irq[1]
		|-> $past(conv_flag_r[aig_pkg::CAL_LSB+1] && conv_en_r[aig_pkg::CAL_LSB+1]))
		else $error("calibration request without enabled flag");
	a_scan_grp_irq: assert property ((scan_en_r[2] && scan_flag_r[2]) |=> irq.scan_done_irq[2])
		else $error("scan group request missing");
	a_scan_shared_irq: assert property (irq.scan_done_hi_irq
		|-> $past(|(scan_en_r[8:5] & scan_flag_r[8:5])))
		else $error("shared scan request without cause");
	a_scan_stop_quiet: assert property ((evt.scan_end[0] && evt.scan_forced[0] && !scan_flag_r[0])
		|=> !scan_flag_r[0])
		else $error("forced stop set scan flag");
	a_lim_clip_irq: assert property ((lim_en_r[7] && evt.lim_clip[7]) |=> ##1
		(irq.limiter_clip_irq || $past(reg_wr)))
		else $error("clip request missing");
	a_ovf_irq_raise: assert property (irq.result_overflow_irq[1]
		|-> $past(conv_flag_r[aig_pkg::OVF_LSB+1] && conv_en_r[aig_pkg::OVF_LSB+1]))
		else $error("overflow request without cause");
	a_cmp_irq_raise: assert property ((cmp_en_r[3] && evt.cmp_match[3]) |=> ##1
		(irq.cmp_match_irq[3] || $past(reg_wr)))
		else $error("compare request missing");
	a_ccmp_or_mode: assert property ((ccmp_en_r[1] && !ccmp_and_r[1] && |(cmp_flag_r & ccmp_mask_r[1]))
		|=> irq.composite_match_irq[1])
		else $error("composite request missing");
	a_fifo_req_thr: assert property ((fifo_en_r[1] && !fifo_st.flush[1]
		&& fifo_st.vacant[1] <= fifo_thr_r[1]) |=> irq.fifo_read_req_irq[1])
		else $error("fifo read request missing");
	a_fifo_req_hi: assert property ((fifo_en_r[8] && !fifo_st.flush[8]
		&& fifo_st.vacant[8] <= fifo_thr_r[8]) |=> irq.fifo_read_req_hi_irq)
		else $error("shared fifo read request missing");
	a_fifo_flush_block: assert property (fifo_st.flush[0] |=> !irq.fifo_read_req_irq[0])
		else $error("read request during flush");
	a_fifo_ovf_irq: assert property (irq.fifo_overflow_irq |-> $past(|(fifo_en_r & fifo_ovf_r)))
		else $error("fifo overflow request without cause");
	a_flag_hold_set: assert property ((conv_flag_r[0] && !(reg_wr && reg_addr == aig_pkg::OFS_CONV_STAT
		&& reg_wdata[0])) |=> conv_flag_r[0])
		else $error("status flag dropped without clear");
endmodule : aig_irq_gate
`default_nettype wire

/* aig_cal_model.sv */
`timescale 1ns/1ps
`default_nettype none
module aig_cal_model #(
	parameter int STEP_CYC = 8
) (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       cal_start,
	output logic      [1:0] cal_pulse,
	output logic            busy
);
	logic [2:0] step_r;
	logic [7:0] cnt_r;

	assign busy = (step_r != 3'h0);

	// hold circuits unused, no dedicated pass
	// every start while idle reruns the full sequence; a start while busy is ignored
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			step_r    <= 3'h0;
			cnt_r     <= 8'h00;
			cal_pulse <= 2'h0;
		end else begin
			cal_pulse <= 2'h0;
			if (step_r == 3'h0) begin
				step_r <= cal_start ? 3'h1 : 3'h0;
				cnt_r  <= 8'h00;
			end else if (cnt_r == 8'(STEP_CYC - 1)) begin
				cnt_r <= 8'h00;
				// even steps end gain/offset, odd steps internal pass
				if (!step_r[0]) begin
					cal_pulse[step_r[2]] <= 1'b1;
				end
				step_r <= (step_r == 3'h4) ? 3'h0 : step_r + 3'h1;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end
endmodule : aig_cal_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [7:0]        eo;
		logic [31:0]       ev;
		logic [7:0]        so;
		aig_pkg::aig_evt_s e;
		aig_pkg::aig_irq_s x;
	} aig_row_s;

	logic              core_clk;
	logic              arst_n;
	logic [7:0]        addr;
	logic [31:0]       wdata;
	logic              wr;
	logic              rd;
	logic [31:0]       rdata;
	aig_pkg::aig_evt_s ev_tb;
	aig_pkg::aig_evt_s ev_dut;
	aig_pkg::aig_fifo_s fst;
	aig_pkg::aig_irq_s irq;
	aig_pkg::aig_irq_s ex_irq;
	logic              cal_start;
	logic [1:0]        cal_pulse;
	logic              cal_busy;
	aig_row_s          rows [9];
	int                fail_count;
	int                total_checks;
	int                n;

	always #20 core_clk = ~core_clk;

	always_comb begin
		ev_dut = ev_tb;
		ev_dut.cal_done = ev_tb.cal_done | cal_pulse;
	end

	aig_irq_gate i_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .evt(ev_dut), .fifo_st(fst), .irq(irq));
	aig_cal_model i_cal (.core_clk(core_clk), .arst_n(arst_n), .cal_start(cal_start),
		.cal_pulse(cal_pulse), .busy(cal_busy));

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic ck_irq(input aig_pkg::aig_irq_s e);
		chk({6'h00, irq}, {6'h00, e});
	endtask : ck_irq

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd_chk

	task automatic pulse(input aig_pkg::aig_evt_s e);
		@(posedge core_clk);
		ev_tb <= e;
		@(posedge core_clk);
		ev_tb <= '0;
	endtask : pulse

	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask : settle

	// busy is read after the edge, so the start edge is not raced
	task automatic run_cal();
		@(posedge core_clk);
		cal_start <= 1'b1;
		@(posedge core_clk);
		cal_start <= 1'b0;
		#1;
		n = 0;
		while (cal_busy && n < 200) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(32'(n < 200), 32'h0000_0001);
		settle();
	endtask : run_cal

	// long enough for every test, with a wide margin
	initial begin
		#(40 * 20000);
		fail_count++;
		results();
	end

	initial begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
		ev_tb = '0;
		fst.vacant = {9{4'hF}};
		fst.flush = 9'h000;
		cal_start = 1'b0;
		fail_count = 0;
		total_checks = 0;
		rows[0] = '{aig_pkg::OFS_CONV_EN, 32'h0000_0001, aig_pkg::OFS_CONV_STAT,
			'{conv_err:2'h1, default:'0}, '{conv_error_irq:2'h1, default:'0}};
		rows[1] = '{aig_pkg::OFS_CONV_EN, 32'h0000_0020, aig_pkg::OFS_CONV_STAT,
			'{res_ovf:2'h2, default:'0}, '{result_overflow_irq:2'h2, default:'0}};
		rows[2] = '{aig_pkg::OFS_SCAN_EN, 32'h0000_01FF, aig_pkg::OFS_SCAN_STAT,
			'{scan_end:9'h01F, default:'0}, '{scan_done_irq:5'h1F, default:'0}};
		rows[3] = '{aig_pkg::OFS_SCAN_EN, 32'h0000_01FF, aig_pkg::OFS_SCAN_STAT,
			'{scan_end:9'h100, default:'0}, '{scan_done_hi_irq:1'h1, default:'0}};
		rows[4] = '{aig_pkg::OFS_SCAN_EN, 32'h0000_01FF, aig_pkg::OFS_SCAN_STAT,
			'{scan_end:9'h1FF, scan_forced:9'h1FF, default:'0}, '0};
		rows[5] = '{aig_pkg::OFS_LIM_EN, 32'h0000_0080, aig_pkg::OFS_LIM_STAT,
			'{lim_clip:9'h080, default:'0}, '{limiter_clip_irq:1'h1, default:'0}};
		rows[6] = '{aig_pkg::OFS_LIM_EN, 32'h0000_0002, aig_pkg::OFS_LIM_STAT,
			'{lim_clip:9'h001, default:'0}, '0};
		rows[7] = '{aig_pkg::OFS_CMP_EN, 32'h0000_000F, aig_pkg::OFS_CMP_STAT,
			'{cmp_match:9'h00F, default:'0}, '{cmp_match_irq:4'hF, default:'0}};
		rows[8] = '{aig_pkg::OFS_FIFO_EN, 32'h0000_0100, aig_pkg::OFS_FIFO_OVF,
			'{fifo_ovf:9'h100, default:'0}, '{fifo_overflow_irq:1'h1, default:'0}};
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		ck_irq('0);
		for (int a = 0; a <= 8'h34; a += 4) begin
			rd_chk(8'(a), 32'h0000_0000);
		end
		$display("test reset done");
		wr_reg(aig_pkg::OFS_CONV_EN, 32'h0000_000C);
		run_cal();
		ck_irq('{cal_done_irq:2'h3, default:'0});
		wr_reg(aig_pkg::OFS_CONV_STAT, 32'h0000_000C);
		wr_reg(aig_pkg::OFS_CONV_EN, 32'h0000_0000);
		settle();
		ck_irq('0);
		$display("test calibration done");
		foreach (rows[i]) begin
			wr_reg(rows[i].eo, rows[i].ev);
			pulse(rows[i].e);
			settle();
			ck_irq(rows[i].x); // level request
			rd_chk(aig_pkg::OFS_IRQ_STAT, {6'h00, rows[i].x});
			wr_reg(rows[i].so, 32'hFFFF_FFFF);
			settle();
			ck_irq('0);
			wr_reg(rows[i].eo, 32'h0000_0000);
			$display("test row %0d done", i);
		end
		wr_reg(aig_pkg::OFS_CONV_EN, 32'h0000_0001);
		@(posedge core_clk);
		addr <= aig_pkg::OFS_CONV_STAT;
		wdata <= 32'h0000_0001;
		wr <= 1'b1;
		ev_tb.conv_err <= 2'h1;
		@(posedge core_clk);
		wr <= 1'b0;
		ev_tb <= '0;
		settle();
		ex_irq = '{conv_error_irq:2'h1, default:'0};
		ck_irq(ex_irq);
		wr_reg(aig_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF);
		rd_chk(aig_pkg::OFS_IRQ_STAT, {6'h00, ex_irq});
		wr_reg(aig_pkg::OFS_CONV_STAT, 32'h0000_0001);
		wr_reg(aig_pkg::OFS_CONV_EN, 32'h0000_0000);
		$display("test set wins done");
		wr_reg(aig_pkg::OFS_CCMP_CFG, 32'h0500_0603);
		pulse('{cmp_match:9'h001, default:'0});
		settle();
		ck_irq('0);
		pulse('{cmp_match:9'h102, default:'0});
		settle();
		ck_irq('{composite_match_irq:2'h3, default:'0});
		wr_reg(aig_pkg::OFS_CMP_STAT, 32'h0000_01FF);
		wr_reg(aig_pkg::OFS_CCMP_CFG, 32'h0000_0000);
		$display("test composite done");
		wr_reg(aig_pkg::OFS_FIFO_THR0, 32'h0000_0003);
		wr_reg(aig_pkg::OFS_FIFO_THR1, 32'h0000_0005);
		wr_reg(aig_pkg::OFS_FIFO_EN, 32'h0000_01FF);
		@(posedge core_clk);
		fst.vacant[0] <= 4'h3;
		fst.vacant[8] <= 4'h5;
		settle();
		ck_irq('{fifo_read_req_irq:5'h01, fifo_read_req_hi_irq:1'h1, default:'0});
		@(posedge core_clk);
		fst.vacant[0] <= 4'h4;
		fst.flush[8] <= 1'b1;
		settle();
		ck_irq('0);
		@(posedge core_clk);
		fst.vacant[0] <= 4'h3;
		fst.flush[0] <= 1'b1;
		settle();
		ck_irq('0);
		$display("test fifo done");
		wr_reg(aig_pkg::OFS_CONV_EN, 32'h0000_000D);
		pulse('{conv_err:2'h1, default:'0});
		settle();
		ck_irq('{conv_error_irq:2'h1, default:'0});
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		ck_irq('0);
		chk(rdata, 32'h0000_0000);
		@(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		ck_irq('0);
		rd_chk(aig_pkg::OFS_CONV_EN, 32'h0000_0000);
		rd_chk(aig_pkg::OFS_CONV_STAT, 32'h0000_0000);
		wr_reg(aig_pkg::OFS_CONV_EN, 32'h0000_000C);
		run_cal();
		ck_irq('{cal_done_irq:2'h3, default:'0});
		wr_reg(aig_pkg::OFS_CONV_STAT, 32'h0000_000C);
		wr_reg(aig_pkg::OFS_CONV_EN, 32'h0000_0000);
		$display("test mid reset done");
		wr_reg(8'h38, 32'hFFFF_FFFF);
		rd_chk(8'h38, 32'h0000_0000);
		rd_chk(8'hFC, 32'h0000_0000);
		$display("test unmapped done");
		results();
	end
endmodule : tb_top
`default_nettype wire
